// ===== pkg/sos_defs.svh
`ifndef SOS_DEFS_SVH
`define SOS_DEFS_SVH

// Byte offsets of the register map
`define SOS_OFS_ASSIGN0 8'h00
`define SOS_OFS_RNG1_A 8'h14
`define SOS_OFS_RNG1_B 8'h18
`define SOS_OFS_RNG2_A 8'h1C
`define SOS_OFS_RNG2_B 8'h20
`define SOS_OFS_CTRL 8'h24
`define SOS_OFS_STATUS 8'h28

// Control register fields
`define SOS_CTRL_INTF_EN 0
`define SOS_CTRL_SS1_USE 1
`define SOS_CTRL_SLS_USE 2
`define SOS_CTRL_RESTART 3
`define SOS_CTRL_W 4

// Status register fields
`define SOS_ST_OUTS 0
`define SOS_ST_INTPOS 5
`define SOS_ST_INTF 6
`define SOS_ST_SS1 7
`define SOS_ST_SLS 8
`define SOS_ST_PERMIT 9

// Reset values
`define SOS_ASSIGN_RST 7'h00
`define SOS_BOUND_RST 32'h0000_0000
`define SOS_CTRL_RST 4'h0

// Assignment reference values
`define SOS_CODE_RANGE1 7'd83
`define SOS_CODE_RANGE2 7'd84
`define SOS_CODE_INTPOS 7'd85
`define SOS_CODE_INTF 7'd86
`define SOS_CODE_SS1 7'd89
`define SOS_CODE_SLS 7'd90
`define SOS_CODE_PASS_A 7'd91
`define SOS_CODE_PASS_E 7'd95

// Bit positions in the synchronised pin vector
`define SOS_PIN_FWD 0
`define SOS_PIN_REV 1
`define SOS_PIN_START 2
`define SOS_PIN_HOME 3
`define SOS_PIN_CANCEL 4
`define SOS_PIN_EMG_N 5
`define SOS_PIN_SERVO_ON 6
`define SOS_PIN_ALM_RST 7
`define SOS_PIN_INT_EN 8
`define SOS_PIN_SS1_N 9
`define SOS_PIN_SLS_N 10
`define SOS_PIN_RESTART 11
`define SOS_PIN_W 12

`define SOS_N_OUT 5
`define SOS_N_PASS_OUT 3
`define SOS_N_COMM 5
`define SOS_POS_W 32

`endif

// ===== pkg/sos_pkg.sv
`include "sos_defs.svh"

package sos_pkg;

    typedef enum logic [1:0]
    {
        SOS_IP_IDLE = 2'b00,
        SOS_IP_MOVING = 2'b01,
        SOS_IP_DONE = 2'b11
    } sos_ip_state_t;

    typedef enum logic [1:0]
    {
        SOS_MODE_POS_PULSE = 2'b00,
        SOS_MODE_POS_INT = 2'b01,
        SOS_MODE_SPEED = 2'b10,
        SOS_MODE_TORQUE = 2'b11
    } sos_mode_t;

    typedef struct packed
    {
        logic interrupt_motion;
        logic in_position;
        logic alarm;
        logic interference_hit;
        logic clear_position;
        sos_mode_t mode;
    } sos_core_t;

    typedef struct packed
    {
        logic [`SOS_PIN_W-1:0] sync1;
        logic [`SOS_PIN_W-1:0] sync2;
        logic [`SOS_PIN_W-1:0] prev;
        logic [`SOS_N_COMM-1:0] comm_sync1;
        logic [`SOS_N_COMM-1:0] comm_sync2;
        sos_ip_state_t ip_state;
        logic interf;
        logic recover_wait;
        logic ss1;
        logic safe_limited_speed_status;
        logic [`SOS_N_OUT-1:0] outs;
        logic [`SOS_N_OUT-1:0][6:0] assign_param;
        logic [3:0][`SOS_POS_W-1:0] bound;
        logic [`SOS_CTRL_W-1:0] ctrl;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
    } sos_state_t;

endpackage

// ===== src/sos_seq_out.sv
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps

module sos_seq_out
    import sos_pkg::*;
(
    input wire logic clock_i, // 20 MHz clock
    input wire logic nrst_i, // Synchronous reset, active low
    input wire logic hsel_i, // AHB slave select
    input wire logic [31:0] haddr_i, // AHB address
    input wire logic [1:0] htrans_i, // AHB transfer type
    input wire logic hwrite_i, // AHB write
    input wire logic [2:0] hsize_i, // AHB size
    input wire logic [31:0] hwdata_i, // AHB write data
    input wire logic hready_i, // AHB bus ready
    output logic [31:0] hrdata_o, // AHB read data
    output logic hreadyout_o, // AHB slave ready
    output logic hresp_o, // AHB response
    input wire logic forward_run_cmd_i, // Forward command pin
    input wire logic reverse_run_cmd_i, // Reverse command pin
    input wire logic pos_start_cmd_i, // Positioning start pin
    input wire logic homing_start_cmd_i, // Homing start pin
    input wire logic pos_cancel_i, // Positioning cancel pin
    input wire logic emergency_stop_input_n_i, // Emergency stop, low stops
    input wire logic servo_on_i, // Servo-on pin
    input wire logic alarm_reset_i, // Alarm reset pin
    input wire logic int_enable_i, // Interrupt input enable pin
    input wire logic ss1_input_n_i, // Safe-stop-1 input, low open
    input wire logic sls_input_n_i, // Safe-limited-speed input, low open
    input wire logic restart_i, // Safety restart pin
    input wire logic [4:0] comm_input_i, // Comm inputs 20..24
    input wire logic signed [31:0] position_i, // Current motor position
    input wire sos_core_t core_i, // Motion core status
    output logic [4:0] sequence_output_o, // Hardware outputs 1..5
    output logic op_permit_o // Regular operation permitted
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic logic range_hit(
        input logic [`SOS_POS_W-1:0] a,
        input logic [`SOS_POS_W-1:0] b,
        input logic signed [`SOS_POS_W-1:0] pos
    );
        logic signed [`SOS_POS_W-1:0] sa;
        logic signed [`SOS_POS_W-1:0] sb;
        sa = $signed(a);
        sb = $signed(b);
        if (sa == sb)
        begin
            range_hit = 1'b0;
        end
        else if (sa < sb)
        begin
            range_hit = (pos >= sa) && (pos <= sb);
        end
        else
        begin
            range_hit = (pos >= sa) || (pos <= sb);
        end
    endfunction

    function automatic logic safety_next(
        input logic cur,
        input logic open_now,
        input logic in_use,
        input logic restart_en,
        input logic restart_edge
    );
        if (!in_use)
        begin
            safety_next = 1'b0;
        end
        else if (open_now)
        begin
            safety_next = 1'b1;
        end
        else if (restart_en)
        begin
            safety_next = cur && !restart_edge;
        end
        else
        begin
            safety_next = 1'b0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    sos_state_t state_reg;
    sos_state_t state_next;

    logic [`SOS_PIN_W-1:0] pins_raw;
    logic [`SOS_PIN_W-1:0] pins;
    logic [`SOS_PIN_W-1:0] rise;
    logic [`SOS_PIN_W-1:0] fall;
    logic pos_servo_on;
    logic start_edge;
    logic [`SOS_N_OUT-1:0] sel_out;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic addr_phase;
    logic [7:0] wr_ofs;
    logic [`SOS_POS_W-1:0] wr_val;
    logic [6:0] code;
    logic [2:0] pass_idx;
    logic [7:0] rd_ofs;

    assign pins_raw = {restart_i, sls_input_n_i, ss1_input_n_i, int_enable_i,
        alarm_reset_i, servo_on_i, emergency_stop_input_n_i, pos_cancel_i,
        homing_start_cmd_i, pos_start_cmd_i, reverse_run_cmd_i,
        forward_run_cmd_i};
    assign pins = state_reg.sync2;
    assign rise = state_reg.sync2 & ~state_reg.prev;
    assign fall = ~state_reg.sync2 & state_reg.prev;

    assign pos_servo_on = pins[`SOS_PIN_SERVO_ON] && pins[`SOS_PIN_EMG_N]
        && !core_i.alarm && (core_i.mode != SOS_MODE_SPEED)
        && (core_i.mode != SOS_MODE_TORQUE);
    assign start_edge = rise[`SOS_PIN_FWD] || rise[`SOS_PIN_REV]
        || rise[`SOS_PIN_START] || rise[`SOS_PIN_HOME];

    assign addr_phase = hsel_i && htrans_i[1] && hready_i;
    assign wr_ofs = state_reg.wr_addr;
    assign wr_val = hwdata_i;
    assign rd_ofs = haddr_i[7:0];

    assign status_word = {22'h00_0000, !state_reg.interf
        && !state_reg.recover_wait, state_reg.safe_limited_speed_status, state_reg.ss1,
        state_reg.interf, state_reg.ip_state != SOS_IP_IDLE, state_reg.outs};

    ////////////////////////////////////////////////////////////////////////
    // Output source selection

    always_comb
    begin
        sel_out = '0;
        code = 7'h00;
        pass_idx = 3'h0;
        for (int i = 0; i < `SOS_N_OUT; i++)
        begin
            code = state_reg.assign_param[i];
            pass_idx = 3'(code - `SOS_CODE_PASS_A);
            unique case (code)
                `SOS_CODE_RANGE1:
                    sel_out[i] = range_hit(state_reg.bound[0],
                        state_reg.bound[1], position_i);
                `SOS_CODE_RANGE2:
                    sel_out[i] = range_hit(state_reg.bound[2],
                        state_reg.bound[3], position_i);
                `SOS_CODE_INTPOS:
                    sel_out[i] = state_reg.ip_state != SOS_IP_IDLE;
                `SOS_CODE_INTF:
                    sel_out[i] = state_reg.interf;
                `SOS_CODE_SS1:
                    sel_out[i] = state_reg.ss1;
                `SOS_CODE_SLS:
                    sel_out[i] = state_reg.safe_limited_speed_status;
                default:
                    if (code >= `SOS_CODE_PASS_A && code <= `SOS_CODE_PASS_E
                        && i < `SOS_N_PASS_OUT)
                    begin
                        sel_out[i] = state_reg.comm_sync2[pass_idx];
                    end
                    else
                    begin
                        sel_out[i] = 1'b0;
                    end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read mux

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (rd_ofs < 8'(`SOS_N_OUT * 4))
        begin
            rd_word = {25'h000_0000, state_reg.assign_param[rd_ofs[4:2]]};
        end
        else if (rd_ofs >= `SOS_OFS_RNG1_A && rd_ofs <= `SOS_OFS_RNG2_B)
        begin
            rd_word = state_reg.bound[2'(rd_ofs[7:2] - 6'd5)];
        end
        else if (rd_ofs == `SOS_OFS_CTRL)
        begin
            rd_word = {28'h000_0000, state_reg.ctrl};
        end
        else if (rd_ofs == `SOS_OFS_STATUS)
        begin
            rd_word = status_word;
        end
        if (haddr_i[31:8] != 24'h00_0000 || haddr_i[1:0] != 2'b00)
        begin
            rd_word = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        state_next = state_reg;
        state_next.sync1 = pins_raw;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;
        state_next.comm_sync1 = comm_input_i;
        state_next.comm_sync2 = state_reg.comm_sync1;
        state_next.outs = sel_out;

        // Interrupt positioning detect
        unique case (state_reg.ip_state)
            SOS_IP_IDLE:
                if (core_i.interrupt_motion && pos_servo_on)
                begin
                    state_next.ip_state = SOS_IP_MOVING;
                end
            SOS_IP_MOVING:
                if (!pos_servo_on || start_edge)
                begin
                    state_next.ip_state = SOS_IP_IDLE;
                end
                else if (rise[`SOS_PIN_CANCEL] || pins[`SOS_PIN_CANCEL])
                begin
                    state_next.ip_state = SOS_IP_IDLE;
                end
                else if (!core_i.interrupt_motion && core_i.in_position)
                begin
                    state_next.ip_state = SOS_IP_DONE;
                end
                else
                begin
                    state_next.ip_state = SOS_IP_MOVING;
                end
            SOS_IP_DONE:
                if (!pos_servo_on || start_edge
                    || fall[`SOS_PIN_INT_EN])
                begin
                    state_next.ip_state = SOS_IP_IDLE;
                end
            default:
                state_next.ip_state = SOS_IP_IDLE;
        endcase

        // Interference and recovery
        if (!state_reg.ctrl[`SOS_CTRL_INTF_EN])
        begin
            state_next.interf = 1'b0;
        end
        else if (core_i.interference_hit)
        begin
            state_next.interf = 1'b1;
        end
        else if (core_i.clear_position)
        begin
            state_next.interf = 1'b0;
        end
        if (core_i.interference_hit && state_reg.ctrl[`SOS_CTRL_INTF_EN]
            && (core_i.mode == SOS_MODE_POS_PULSE
            || core_i.mode == SOS_MODE_SPEED))
        begin
            state_next.recover_wait = 1'b1;
        end
        else if (!pins[`SOS_PIN_SERVO_ON]
            && ((core_i.mode == SOS_MODE_POS_PULSE
            && pins[`SOS_PIN_ALM_RST]) || (core_i.mode == SOS_MODE_SPEED
            && !pins[`SOS_PIN_FWD] && !pins[`SOS_PIN_REV])))
        begin
            state_next.recover_wait = 1'b0;
        end

        // Safety status
        state_next.ss1 = safety_next(state_reg.ss1, !pins[`SOS_PIN_SS1_N],
            state_reg.ctrl[`SOS_CTRL_SS1_USE],
            state_reg.ctrl[`SOS_CTRL_RESTART], rise[`SOS_PIN_RESTART]);
        state_next.safe_limited_speed_status = safety_next(state_reg.safe_limited_speed_status, !pins[`SOS_PIN_SLS_N],
            state_reg.ctrl[`SOS_CTRL_SLS_USE],
            state_reg.ctrl[`SOS_CTRL_RESTART], rise[`SOS_PIN_RESTART]);

        // Bus slave, zero wait states
        state_next.wr_pend = addr_phase && hwrite_i;
        if (addr_phase)
        begin
            state_next.wr_addr = haddr_i[31:8] == 24'h00_0000
                && haddr_i[1:0] == 2'b00 ? haddr_i[7:0] : 8'hFF;
            state_next.hrdata = hwrite_i ? 32'h0000_0000 : rd_word;
        end
        if (state_reg.wr_pend)
        begin
            if (wr_ofs < 8'(`SOS_N_OUT * 4))
            begin
                state_next.assign_param[wr_ofs[4:2]] =
                    hwdata_i[6:0];
            end
            else if (wr_ofs >= `SOS_OFS_RNG1_A && wr_ofs <= `SOS_OFS_RNG2_B)
            begin
                state_next.bound[2'(wr_ofs[7:2] - 6'd5)] = wr_val;
            end
            else if (wr_ofs == `SOS_OFS_CTRL)
            begin
                state_next.ctrl = hwdata_i[`SOS_CTRL_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= '0;
            state_reg.sync1 <= `SOS_PIN_W'(12'h0E0);
            state_reg.sync2 <= `SOS_PIN_W'(12'h0E0);
            state_reg.prev <= `SOS_PIN_W'(12'h0E0);
            state_reg.ip_state <= SOS_IP_IDLE;
            state_reg.assign_param <= {`SOS_N_OUT{`SOS_ASSIGN_RST}};
            state_reg.bound <= {4{`SOS_BOUND_RST}};
            state_reg.ctrl <= `SOS_CTRL_RST;
            state_reg.wr_addr <= 8'hFF;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign hrdata_o = state_reg.hrdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign sequence_output_o = state_reg.outs;
    assign op_permit_o = !state_reg.interf
        && !state_reg.recover_wait;

endmodule

// ===== verif/sos_seq_out_asserts.sv
`timescale 1ns/100ps
`include "sos_defs.svh"
module sos_seq_out_asserts
    import sos_pkg::*;
(
    input wire logic clock_i, // Clock
    input wire logic nrst_i, // Reset, active low
    input wire logic hsel_i, // Select
    input wire logic [31:0] haddr_i, // Address
    input wire logic [1:0] htrans_i, // Transfer type
    input wire logic hwrite_i, // Write
    input wire logic [31:0] hwdata_i, // Write data
    input wire logic hready_i, // Bus ready
    input wire logic hreadyout_o, // Slave ready
    input wire logic hresp_o, // Response
    input wire logic forward_run_cmd_i, // Forward command
    input wire logic emergency_stop_input_n_i, // Emergency stop
    input wire logic ss1_input_n_i, // Safe-stop-1 input
    input wire logic sls_input_n_i, // Safe-limited-speed input
    input wire logic [4:0] comm_input_i, // Comm inputs
    input wire sos_core_t core_i, // Core status
    input wire logic [4:0] sequence_output_o, // Outputs
    input wire logic op_permit_o // Operation permit
);
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [6:0] code;
    logic [3:0] ctrl;
    logic [4:0] quiet;
    logic settled;
    assign settled = quiet > 5'h03;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of output one assignment and control
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            code <= 7'h00;
            ctrl <= 4'h0;
            quiet <= 5'h00;
        end
        else
        begin
            wr_pend <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
            wr_addr <= haddr_i[7:0];
            if (wr_pend && wr_addr == `SOS_OFS_ASSIGN0)
                code <= hwdata_i[6:0];
            if (wr_pend && wr_addr == `SOS_OFS_CTRL)
                ctrl <= hwdata_i[3:0];
            if (wr_pend)
                quiet <= 5'h00;
            else if (quiet != 5'h1F)
                quiet <= quiet + 5'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_bus;
        hreadyout_o && !hresp_o;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer wrong");
    property p_rst;
        disable iff (1'b0)
        !nrst_i |=> sequence_output_o == 5'h00 && op_permit_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_pass;
        ($stable(comm_input_i[0]) && code == `SOS_CODE_PASS_A)[*6] ##0 settled
        |-> sequence_output_o[0] == comm_input_i[0];
    endproperty
    a_pass: assert property (p_pass) else $error("pass mismatch");
    property p_ss1_open;
        (!ss1_input_n_i && code == `SOS_CODE_SS1 && ctrl[1])[*6] ##0 settled
        |-> sequence_output_o[0];
    endproperty
    a_ss1_open: assert property (p_ss1_open) else $error("ss1 off");
    property p_ss1_unused;
        (code == `SOS_CODE_SS1 && !ctrl[1])[*6] ##0 settled
        |-> !sequence_output_o[0];
    endproperty
    a_ss1_unused: assert property (p_ss1_unused)
        else $error("ss1 on");
    property p_sls_closed;
        (sls_input_n_i && code == `SOS_CODE_SLS && !ctrl[3])[*6] ##0 settled
        |-> !sequence_output_o[0];
    endproperty
    a_sls_closed: assert property (p_sls_closed)
        else $error("sls on");
    property p_intf_off;
        (code == `SOS_CODE_INTF && !ctrl[0])[*6] ##0 settled
        |-> !sequence_output_o[0];
    endproperty
    a_intf_off: assert property (p_intf_off) else $error("intf on");
    property p_start;
        (!core_i.interrupt_motion)[*3] ##0
        ($rose(forward_run_cmd_i) && code == `SOS_CODE_INTPOS) ##1
        (!core_i.interrupt_motion && code == `SOS_CODE_INTPOS)[*5] ##0 settled
        |-> !sequence_output_o[0];
    endproperty
    a_start: assert property (p_start) else $error("detect kept");
    property p_emg;
        (!emergency_stop_input_n_i && code == `SOS_CODE_INTPOS)[*6] ##0
        settled |-> !sequence_output_o[0];
    endproperty
    a_emg: assert property (p_emg) else $error("detect on in stop");
    c_pass: cover property (code == `SOS_CODE_PASS_A && sequence_output_o[0]);
    c_intpos: cover property (code == `SOS_CODE_INTPOS
        && sequence_output_o[0]);
    c_permit: cover property ($fell(op_permit_o));
endmodule

bind sos_seq_out sos_seq_out_asserts sos_seq_out_asserts_i
(
    .clock_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i,
    .hready_i, .hreadyout_o, .hresp_o, .forward_run_cmd_i,
    .emergency_stop_input_n_i, .ss1_input_n_i, .sls_input_n_i,
    .comm_input_i, .core_i, .sequence_output_o, .op_permit_o
);

// ===== verif/sos_host_model.sv
`timescale 1ns/100ps
module sos_host_model
(
    input wire logic clock_i, // Clock
    input wire logic [4:0] comm_req_i, // Comm inputs to send
    input wire logic [1:0] run_req_i, // Reverse, forward requests
    input wire logic recover_i, // Interference recovery request
    input wire logic [4:0] seq_i, // Sequence outputs read
    output logic [4:0] comm_o, // Comm inputs 20..24
    output logic fwd_o, // Forward command
    output logic rev_o, // Reverse command
    output logic servo_on_o, // Servo-on
    output logic alarm_reset_o, // Alarm reset
    output logic [4:0] seen_o // Outputs as read
);
    initial
    begin
        comm_o = 5'h00;
        fwd_o = 1'b0;
        rev_o = 1'b0;
        servo_on_o = 1'b1;
        alarm_reset_o = 1'b0;
        seen_o = 5'h00;
    end
    always @(posedge clock_i)
    begin
        comm_o <= comm_req_i;
        seen_o <= seq_i;
        servo_on_o <= !recover_i;
        alarm_reset_o <= recover_i;
        fwd_o <= run_req_i[0] & !recover_i;
        rev_o <= run_req_i[1] & !recover_i;
    end
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`include "sos_defs.svh"
module tb_top
    import sos_pkg::*;
;
    logic clock_i, nrst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
    logic pos_start_cmd_i, homing_start_cmd_i, pos_cancel_i, restart_i;
    logic emergency_stop_input_n_i, int_enable_i, ss1_input_n_i;
    logic sls_input_n_i, op_permit_o, recover;
    logic forward_run_cmd_i, reverse_run_cmd_i, servo_on_i, alarm_reset_i;
    logic [1:0] htrans_i, run_req;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd_val;
    logic [4:0] comm_input_i, sequence_output_o, comm_req, seen;
    logic signed [31:0] position_i;
    sos_core_t core_i;
    typedef struct {logic rd; logic [31:0] mask; logic [31:0] exp;} sos_note_t;
    sos_note_t q[$];
    sos_note_t n;
    event obs;
    int mismatches, checks;
    assign hready_i = hreadyout_o;
    sos_seq_out sos_seq_out_i
    (
        .clock_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
        .hresp_o, .forward_run_cmd_i, .reverse_run_cmd_i, .pos_start_cmd_i,
        .homing_start_cmd_i, .pos_cancel_i, .emergency_stop_input_n_i,
        .servo_on_i, .alarm_reset_i, .int_enable_i, .ss1_input_n_i,
        .sls_input_n_i, .restart_i, .comm_input_i, .position_i, .core_i,
        .sequence_output_o, .op_permit_o
    );
    sos_host_model sos_host_model_i
    (
        .clock_i, .comm_req_i(comm_req), .run_req_i(run_req),
        .recover_i(recover), .seq_i(sequence_output_o),
        .comm_o(comm_input_i), .fwd_o(forward_run_cmd_i),
        .rev_o(reverse_run_cmd_i), .servo_on_o(servo_on_i),
        .alarm_reset_o(alarm_reset_i), .seen_o(seen)
    );
    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= {24'h00_0000, a};
        hwrite_i <= w;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clock_i);
        while (hreadyout_o !== 1'b1) @(posedge clock_i);
        rd_val = hrdata_o;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        q.push_back('{1'b1, 32'hFFFF_FFFF, e});
        -> obs;
    endtask
    task out_chk(input logic [5:0] m, input logic [5:0] e);
        repeat (8) @(posedge clock_i);
        q.push_back('{1'b0, {26'h000_0000, m}, {26'h000_0000, e}});
        -> obs;
    endtask
    task core_set(input logic mot, inp, hit, clr, input sos_mode_t md);
        core_i <= {mot, inp, 1'b0, hit, clr, md};
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial
    begin
        forever
        begin
            @obs;
            n = q.pop_front();
            check((n.rd ? rd_val : {26'h000_0000, op_permit_o, seen}) & n.mask,
                n.exp);
        end
    end
    initial
    begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        print_verdict;
    end
    initial
    begin
        logic [4:0] v;
        int k;
        {nrst_i, hsel_i, hwrite_i, pos_start_cmd_i, homing_start_cmd_i} = 0;
        {pos_cancel_i, restart_i, recover, run_req, htrans_i} = 0;
        {emergency_stop_input_n_i, int_enable_i, ss1_input_n_i} = 3'h7;
        sls_input_n_i = 1'b1;
        {haddr_i, hwdata_i, position_i, comm_req} = 0;
        core_i = {5'h00, SOS_MODE_POS_INT};
        mismatches = 0;
        checks = 0;
        void'($urandom(32'h766b));
        repeat (3) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        rd_chk(`SOS_OFS_ASSIGN0, 32'h0000_0000);
        rd_chk(`SOS_OFS_STATUS, 32'h0000_0200);
        ahb(1'b1, 8'h80, 32'hFFFF_FFFF);
        rd_chk(8'h80, 32'h0000_0000);
        ahb(1'b1, `SOS_OFS_ASSIGN0, 32'h0000_005F);
        rd_chk(`SOS_OFS_ASSIGN0, 32'h0000_005F);
        for (int c = 0; c < 5; c++)
        begin
            v = 5'($urandom);
            k = c % 3;
            comm_req <= v;
            ahb(1'b1, 8'(4 * k), 32'(`SOS_CODE_PASS_A + c));
            ahb(1'b1, 8'h0C, 32'(`SOS_CODE_PASS_A + c));
            out_chk(6'(24 | 1 << k), 6'(v[c]) << k);
        end
        ahb(1'b1, 8'h00, 32'(`SOS_CODE_RANGE1));
        ahb(1'b1, 8'h04, 32'(`SOS_CODE_RANGE2));
        ahb(1'b1, `SOS_OFS_RNG1_A, 32'h0000_0064);
        ahb(1'b1, `SOS_OFS_RNG1_B, 32'h0000_00C8);
        ahb(1'b1, `SOS_OFS_RNG2_A, 32'h0000_0032);
        ahb(1'b1, `SOS_OFS_RNG2_B, 32'h0000_0032);
        position_i <= 32'sd100 + 32'($urandom_range(100));
        out_chk(6'h03, 6'h01);
        position_i <= 32'sd201;
        out_chk(6'h03, 6'h00);
        ahb(1'b1, `SOS_OFS_RNG1_A, 32'h0000_00C8);
        ahb(1'b1, `SOS_OFS_RNG1_B, 32'h0000_0064);
        position_i <= 32'sd50;
        out_chk(6'h03, 6'h01);
        for (int s = 0; s < 2; s++)
        begin
            ahb(1'b1, `SOS_OFS_CTRL, 32'h0000_0000);
            ahb(1'b1, 8'h00, 32'(s ? `SOS_CODE_SLS : `SOS_CODE_SS1));
            ahb(1'b1, 8'h04, 32'(s ? `SOS_CODE_SS1 : `SOS_CODE_SLS));
            {ss1_input_n_i, sls_input_n_i} <= 2'h0;
            out_chk(6'h03, 6'h00);
            ahb(1'b1, `SOS_OFS_CTRL, 32'h0000_0006);
            out_chk(6'h03, 6'h03);
            {ss1_input_n_i, sls_input_n_i} <= 2'h3;
            out_chk(6'h03, 6'h00);
            ahb(1'b1, `SOS_OFS_CTRL, 32'h0000_000E);
            {ss1_input_n_i, sls_input_n_i} <= 2'h0;
            out_chk(6'h03, 6'h03);
            {ss1_input_n_i, sls_input_n_i} <= 2'h3;
            out_chk(6'h03, 6'h03);
            restart_i <= 1'b1;
            out_chk(6'h03, 6'h00);
            restart_i <= 1'b0;
        end
        ahb(1'b1, `SOS_OFS_CTRL, 32'h0000_0000);
        ahb(1'b1, 8'h00, 32'(`SOS_CODE_INTF));
        for (int i = 0; i < 2; i++)
        begin
            core_set(0, 0, 1, 0, i ? SOS_MODE_POS_PULSE : SOS_MODE_SPEED);
            out_chk(6'h01, 6'h00);
            ahb(1'b1, `SOS_OFS_CTRL, 32'h0000_0001);
            out_chk(6'h21, 6'h01);
            core_set(0, 0, 0, 1, i ? SOS_MODE_POS_PULSE : SOS_MODE_SPEED);
            out_chk(6'h21, 6'h00);
            recover <= 1'b1;
            out_chk(6'h20, 6'h20);
            recover <= 1'b0;
            ahb(1'b1, `SOS_OFS_CTRL, 32'h0000_0000);
        end
        ahb(1'b1, 8'h00, 32'(`SOS_CODE_INTPOS));
        for (int w = 0; w < 8; w++)
        begin
            core_set(1, 0, 0, 0, SOS_MODE_POS_INT);
            out_chk(6'h01, 6'h01);
            if (w < 6)
            begin
                core_set(0, w < 5, 0, 0, SOS_MODE_POS_INT);
                out_chk(6'h01, 6'h01);
            end
            case (w)
                0: int_enable_i <= 1'b0;
                1: run_req <= 2'h1;
                2: run_req <= 2'h2;
                3: pos_start_cmd_i <= 1'b1;
                4: homing_start_cmd_i <= 1'b1;
                5: pos_cancel_i <= 1'b1;
                6: emergency_stop_input_n_i <= 1'b0;
                default: core_set(1, 0, 0, 0, SOS_MODE_SPEED);
            endcase
            out_chk(6'h01, 6'h00);
            core_set(0, 0, 0, 0, SOS_MODE_POS_INT);
            {run_req, pos_start_cmd_i, homing_start_cmd_i, pos_cancel_i} <= 0;
            {emergency_stop_input_n_i, int_enable_i} <= 2'h3;
            repeat (8) @(posedge clock_i);
        end
        print_verdict;
    end
endmodule
